/* File: rtl/ssim_pkg.sv */
// Purpose: Shared constants for the state/stage interrupt enable block
// Assumes: Avalon-MM slave with 32-bit data and byte addresses
// Notes: Offsets are byte addresses, one aligned word per register
package ssim_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam int BE_W = DATA_W / 8;
	localparam int ENB_W = 16;
	localparam int ST_W = 2;
	localparam int DS_W = 3;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFF_ENABLE = 4'h0;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h4;
	localparam logic [ADDR_W-1:0] OFF_MASK = 4'h8;
	localparam logic [ADDR_W-1:0] OFF_DSTATE = 4'hc;

	// Enable mask bit positions
	localparam int B_CFG = 5;
	localparam int B_SUSPEND_STATE_ENABLE = 4;
	localparam int B_WR = 3;
	localparam int B_RD = 2;
	localparam int B_END = 1;
	localparam logic [ENB_W-1:0] ENB_IMPL = 16'h003e;
	localparam logic [ENB_W-1:0] ENB_RESET = 16'h0000;

	// Status and interrupt mask bit positions
	localparam int ST_DEV = 0;
	localparam int ST_CTRL = 1;
	localparam logic [ST_W-1:0] ST_RESET = 2'h0;

	// Device state encodings
	localparam logic [DS_W-1:0] DS_POWERED = 3'h0;
	localparam logic [DS_W-1:0] DS_DEFAULT = 3'h1;
	localparam logic [DS_W-1:0] DS_ADDRESS = 3'h2;
	localparam logic [DS_W-1:0] DS_CONFIGURED = 3'h3;
	localparam int DS_SUSPEND_STATE_ENABLE_BIT = 2;
endpackage : ssim_pkg

/* File: rtl/ssim_evt_if.sv */
// Purpose: Bundle between register side and event qualifier
// Assumes: One clock domain
// Notes: Qualifier only reads the enables
interface ssim_evt_if;
	logic [ssim_pkg::ENB_W-1:0] enables;
	logic [ssim_pkg::DS_W-1:0] device_state;
	logic wr_status_entry;
	logic rd_status_entry;
	logic ctrl_end;
	logic state_change_irq;
	logic ctrl_stage_irq;

	modport qual (
		input enables,
		input device_state,
		input wr_status_entry,
		input rd_status_entry,
		input ctrl_end,
		output state_change_irq,
		output ctrl_stage_irq
	);
	modport regs (
		output enables,
		output device_state,
		output wr_status_entry,
		output rd_status_entry,
		output ctrl_end,
		input state_change_irq,
		input ctrl_stage_irq
	);
endinterface : ssim_evt_if

/* File: rtl/ssim_evt_qual.sv */
// Purpose: Gate state-change and control-stage events by enable bits
// Assumes: Device state and stage strobes on the system clock
// Notes: Outputs are one-cycle combinational pulses
module ssim_evt_qual (
	input wire logic clock,
	input wire logic rstn,
	ssim_evt_if.qual evt
);
	import ssim_pkg::*;

	logic [DS_W-1:0] prev_state_r;
	logic cfg_entry;
	logic suspend_state_enable_entry;

	// Previous state for entry detection
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			prev_state_r <= DS_POWERED;
		end else begin
			prev_state_r <= evt.device_state;
		end
	end

	assign cfg_entry = (evt.device_state == DS_CONFIGURED) && (prev_state_r != DS_CONFIGURED);
	assign suspend_state_enable_entry = evt.device_state[DS_SUSPEND_STATE_ENABLE_BIT] && !prev_state_r[DS_SUSPEND_STATE_ENABLE_BIT];

	assign evt.state_change_irq = (cfg_entry && evt.enables[B_CFG])
		|| (suspend_state_enable_entry && evt.enables[B_SUSPEND_STATE_ENABLE]);
	assign evt.ctrl_stage_irq = (evt.wr_status_entry && evt.enables[B_WR])
		|| (evt.rd_status_entry && evt.enables[B_RD])
		|| (evt.ctrl_end && evt.enables[B_END]);

	suspend_state_enable_gate_a: assert property (@(posedge clock) disable iff (!rstn)
		(suspend_state_enable_entry && !cfg_entry) |-> (evt.state_change_irq == evt.enables[B_SUSPEND_STATE_ENABLE]))
		else $error("suspend entry gating wrong");
	end_gate_a: assert property (@(posedge clock) disable iff (!rstn)
		(evt.ctrl_end && !evt.wr_status_entry && !evt.rd_status_entry)
		|-> (evt.ctrl_stage_irq == evt.enables[B_END]))
		else $error("control end gating wrong");
endmodule : ssim_evt_qual

/* File: rtl/ssim_state_stage_irq_mask.sv */
// Purpose: Enable bits for state-change and control-stage interrupts
// Assumes: Event strobes and device state come from same-clock logic
// Notes: Avalon-MM slave, one wait cycle per access
// Contract
// - Configured entry interrupts only when enabled
// - Suspend enable bit 4 gates suspend entry
// - Bit 3 gates write status stage entry
// - Bit 2 gates read status stage entry
// - Bit 1 gates control transfer end
// - Software reads/writes enables; hardware never modifies
// - Disabled events still let device state advance
// - State codes: powered, default, address, configured, suspend
module ssim_state_stage_irq_mask (
	input wire logic clock,
	input wire logic rstn,
	input wire logic [ssim_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [ssim_pkg::DATA_W-1:0] avs_writedata,
	input wire logic [ssim_pkg::BE_W-1:0] avs_byteenable,
	output logic [ssim_pkg::DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [ssim_pkg::DS_W-1:0] device_state_field,
	input wire logic wr_status_entry,
	input wire logic rd_status_entry,
	input wire logic ctrl_end,
	output logic irq
);
	import ssim_pkg::*;

	ssim_evt_if evt ();

	logic ack_r;
	logic [DATA_W-1:0] rdata_r;
	logic [DATA_W-1:0] rdata_nxt;
	logic [ENB_W-1:0] enable_r;
	logic [ST_W-1:0] status_r;
	logic [ST_W-1:0] mask_r;
	logic [DS_W-1:0] dev_state_r;
	logic req;
	logic wr_acc;
	logic [ST_W-1:0] st_set;
	logic [ST_W-1:0] st_clr;

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
		return a[ADDR_W-1:2] == off[ADDR_W-1:2];
	endfunction : hit

	// Byte-lane merge of a write into a 16-bit register
	function automatic logic [ENB_W-1:0] merge(input logic [ENB_W-1:0] old,
		input logic [DATA_W-1:0] wd, input logic [BE_W-1:0] be);
		logic [ENB_W-1:0] res;
		res = old;
		if (be[0]) begin
			res[7:0] = wd[7:0];
		end
		if (be[1]) begin
			res[15:8] = wd[15:8];
		end
		return res;
	endfunction : merge

	ssim_evt_qual u_qual (
		.clock(clock),
		.rstn(rstn),
		.evt(evt.qual)
	);

	assign evt.enables = enable_r;
	assign evt.device_state = device_state_field;
	assign evt.wr_status_entry = wr_status_entry;
	assign evt.rd_status_entry = rd_status_entry;
	assign evt.ctrl_end = ctrl_end;

	// Bus handshake: first cycle waits, second completes
	assign req = avs_read || avs_write;
	assign avs_waitrequest = req && !ack_r;
	assign wr_acc = avs_write && ack_r;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= req && !ack_r;
		end
	end

	always_comb begin
		rdata_nxt = '0;
		if (hit(avs_address, OFF_ENABLE)) begin
			rdata_nxt[ENB_W-1:0] = enable_r;
		end else if (hit(avs_address, OFF_STATUS)) begin
			rdata_nxt[ST_W-1:0] = status_r;
		end else if (hit(avs_address, OFF_MASK)) begin
			rdata_nxt[ST_W-1:0] = mask_r;
		end else if (hit(avs_address, OFF_DSTATE)) begin
			rdata_nxt[DS_W-1:0] = dev_state_r;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rdata_r <= '0;
		end else if (avs_read && !ack_r) begin
			rdata_r <= rdata_nxt;
		end
	end
	assign avs_readdata = rdata_r;

	// Enables change only by software writes
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			enable_r <= ENB_RESET;
		end else if (wr_acc && hit(avs_address, OFF_ENABLE)) begin
			enable_r <= merge(enable_r, avs_writedata, avs_byteenable) & ENB_IMPL;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			mask_r <= ST_RESET;
		end else if (wr_acc && hit(avs_address, OFF_MASK) && avs_byteenable[0]) begin
			mask_r <= avs_writedata[ST_W-1:0];
		end
	end

	// Sticky status, set wins over write-one-to-clear
	assign st_set = {evt.ctrl_stage_irq, evt.state_change_irq};
	assign st_clr = (wr_acc && hit(avs_address, OFF_STATUS) && avs_byteenable[0])
		? avs_writedata[ST_W-1:0] : ST_RESET;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			status_r <= ST_RESET;
		end else begin
			status_r <= (status_r & ~st_clr) | st_set;
		end
	end

	// State copy follows the bus state regardless of enables
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			dev_state_r <= DS_POWERED;
		end else begin
			dev_state_r <= device_state_field;
		end
	end

	assign irq = |(status_r & mask_r);

	cfg_irq_a: assert property (@(posedge clock) disable iff (!rstn)
		(device_state_field == DS_CONFIGURED && dev_state_r != DS_CONFIGURED
		&& enable_r[B_CFG]) |=> status_r[ST_DEV])
		else $error("configured entry lost");
	dev_quiet_a: assert property (@(posedge clock) disable iff (!rstn)
		(!enable_r[B_CFG] && !enable_r[B_SUSPEND_STATE_ENABLE] && !status_r[ST_DEV]) |=> !status_r[ST_DEV])
		else $error("state interrupt while disabled");
	suspend_state_enable_irq_a: assert property (@(posedge clock) disable iff (!rstn)
		(device_state_field[DS_SUSPEND_STATE_ENABLE_BIT] && !dev_state_r[DS_SUSPEND_STATE_ENABLE_BIT] && enable_r[B_SUSPEND_STATE_ENABLE])
		|=> status_r[ST_DEV])
		else $error("suspend entry lost");
	wr_stage_a: assert property (@(posedge clock) disable iff (!rstn)
		(wr_status_entry && enable_r[B_WR]) |=> status_r[ST_CTRL])
		else $error("write status stage lost");
	rd_stage_a: assert property (@(posedge clock) disable iff (!rstn)
		(rd_status_entry && enable_r[B_RD]) |=> status_r[ST_CTRL])
		else $error("read status stage lost");
	ctrl_quiet_a: assert property (@(posedge clock) disable iff (!rstn)
		(enable_r[B_WR:B_END] == 3'h0 && !status_r[ST_CTRL]) |=> !status_r[ST_CTRL])
		else $error("stage interrupt while disabled");
	en_stable_a: assert property (@(posedge clock) disable iff (!rstn)
		!(wr_acc && hit(avs_address, OFF_ENABLE)) |=> $stable(enable_r))
		else $error("enable bits changed without write");
	en_read_a: assert property (@(posedge clock) disable iff (!rstn)
		(avs_read && avs_waitrequest && hit(avs_address, OFF_ENABLE))
		|=> !avs_waitrequest && avs_readdata[ENB_W-1:0] == $past(enable_r))
		else $error("enable readback wrong");
	state_view_a: assert property (@(posedge clock) disable iff (!rstn)
		rstn |=> dev_state_r == $past(device_state_field))
		else $error("device state copy stalled");
	irq_level_a: assert property (@(posedge clock) disable iff (!rstn)
		irq == ((status_r[ST_DEV] && mask_r[ST_DEV]) || (status_r[ST_CTRL] && mask_r[ST_CTRL])))
		else $error("interrupt level wrong");

	// Bus handshake: one wait cycle, data stands between reads
	wait_once_a: assert property (@(posedge clock) disable iff (!rstn)
		(req && avs_waitrequest)
		|=> !avs_waitrequest)
		else $error("more than one wait cycle");
	ack_pulse_a: assert property (@(posedge clock) disable iff (!rstn)
		ack_r
		|=> !ack_r)
		else $error("acknowledge longer than one cycle");
	idle_nowait_a: assert property (@(posedge clock) disable iff (!rstn)
		!req
		|-> !avs_waitrequest)
		else $error("wait asserted while idle");
	rd_stand_a: assert property (@(posedge clock) disable iff (!rstn)
		!(avs_read && !ack_r)
		|=> $stable(avs_readdata))
		else $error("read data moved between reads");

	// Readback of status, mask and device state; reserved enable bits stay clear
	st_read_a: assert property (@(posedge clock) disable iff (!rstn)
		(avs_read && avs_waitrequest && hit(avs_address, OFF_STATUS))
		|=> avs_readdata == DATA_W'($past(status_r)))
		else $error("status readback wrong");
	mask_read_a: assert property (@(posedge clock) disable iff (!rstn)
		(avs_read && avs_waitrequest && hit(avs_address, OFF_MASK))
		|=> avs_readdata == DATA_W'($past(mask_r)))
		else $error("mask readback wrong");
	ds_read_a: assert property (@(posedge clock) disable iff (!rstn)
		(avs_read && avs_waitrequest && hit(avs_address, OFF_DSTATE))
		|=> avs_readdata == DATA_W'($past(dev_state_r)))
		else $error("device state readback wrong");
	en_resv_a: assert property (@(posedge clock) disable iff (!rstn)
		1'b1
		|-> (enable_r & ~ENB_IMPL) == ENB_RESET)
		else $error("reserved enable bit set");

	// Software writes land whole
	en_write_a: assert property (@(posedge clock) disable iff (!rstn)
		(wr_acc && hit(avs_address, OFF_ENABLE) && avs_byteenable[0] && avs_byteenable[1])
		|=> enable_r == (ENB_W'($past(avs_writedata)) & ENB_IMPL))
		else $error("enable write lost");
	mask_write_a: assert property (@(posedge clock) disable iff (!rstn)
		(wr_acc && hit(avs_address, OFF_MASK) && avs_byteenable[0])
		|=> mask_r == ST_W'($past(avs_writedata)))
		else $error("mask write lost");

	// Sticky status: held, cleared by a one, set wins
	dev_hold_a: assert property (@(posedge clock) disable iff (!rstn)
		(status_r[ST_DEV] && !st_clr[ST_DEV])
		|=> status_r[ST_DEV])
		else $error("state status dropped");
	ctrl_hold_a: assert property (@(posedge clock) disable iff (!rstn)
		(status_r[ST_CTRL] && !st_clr[ST_CTRL])
		|=> status_r[ST_CTRL])
		else $error("stage status dropped");
	dev_clear_a: assert property (@(posedge clock) disable iff (!rstn)
		(st_clr[ST_DEV] && !st_set[ST_DEV])
		|=> !status_r[ST_DEV])
		else $error("state status not cleared");
	ctrl_clear_a: assert property (@(posedge clock) disable iff (!rstn)
		(st_clr[ST_CTRL] && !st_set[ST_CTRL])
		|=> !status_r[ST_CTRL])
		else $error("stage status not cleared");
	dev_wins_a: assert property (@(posedge clock) disable iff (!rstn)
		st_set[ST_DEV]
		|=> status_r[ST_DEV])
		else $error("state set lost to clear");
	ctrl_wins_a: assert property (@(posedge clock) disable iff (!rstn)
		st_set[ST_CTRL]
		|=> status_r[ST_CTRL])
		else $error("stage set lost to clear");

	// Each event gated by its own enable
	cfg_gate_a: assert property (@(posedge clock) disable iff (!rstn)
		(device_state_field == DS_CONFIGURED && dev_state_r != DS_CONFIGURED)
		|-> evt.state_change_irq == enable_r[B_CFG])
		else $error("configured entry gating wrong");
	wr_gate_a: assert property (@(posedge clock) disable iff (!rstn)
		(wr_status_entry && !rd_status_entry && !ctrl_end)
		|-> evt.ctrl_stage_irq == enable_r[B_WR])
		else $error("write status gating wrong");
	rd_gate_a: assert property (@(posedge clock) disable iff (!rstn)
		(rd_status_entry && !wr_status_entry && !ctrl_end)
		|-> evt.ctrl_stage_irq == enable_r[B_RD])
		else $error("read status gating wrong");
	end_irq_a: assert property (@(posedge clock) disable iff (!rstn)
		(ctrl_end && enable_r[B_END])
		|=> status_r[ST_CTRL])
		else $error("control end lost");
	end_none_a: assert property (@(posedge clock) disable iff (!rstn)
		(ctrl_end && !enable_r[B_END] && !wr_status_entry && !rd_status_entry)
		|-> !evt.ctrl_stage_irq)
		else $error("control end raised while disabled");

	// Codes that can raise no state interrupt
	suspend_state_enable_none_a: assert property (@(posedge clock) disable iff (!rstn)
		(device_state_field[DS_SUSPEND_STATE_ENABLE_BIT] && !enable_r[B_SUSPEND_STATE_ENABLE])
		|-> !evt.state_change_irq)
		else $error("suspend code raised configured entry");
	low_none_a: assert property (@(posedge clock) disable iff (!rstn)
		(!device_state_field[DS_SUSPEND_STATE_ENABLE_BIT] && device_state_field != DS_CONFIGURED)
		|-> !evt.state_change_irq)
		else $error("low state code raised interrupt");
	state_free_a: assert property (@(posedge clock) disable iff (!rstn)
		(rstn && !enable_r[B_CFG] && !enable_r[B_SUSPEND_STATE_ENABLE])
		|=> dev_state_r == $past(device_state_field))
		else $error("state copy held while disabled");

	// Interrupt level follows unmasked status
	irq_rise_a: assert property (@(posedge clock) disable iff (!rstn)
		(st_set[ST_DEV] && mask_r[ST_DEV] && !(wr_acc && hit(avs_address, OFF_MASK)))
		|=> irq)
		else $error("state interrupt not raised");
	irq_ctrl_a: assert property (@(posedge clock) disable iff (!rstn)
		(st_set[ST_CTRL] && mask_r[ST_CTRL] && !(wr_acc && hit(avs_address, OFF_MASK)))
		|=> irq)
		else $error("stage interrupt not raised");
	irq_off_a: assert property (@(posedge clock) disable iff (!rstn)
		(mask_r == ST_RESET)
		|-> !irq)
		else $error("interrupt while fully masked");
endmodule : ssim_state_stage_irq_mask

/* File: sim/ssim_state_stage_irq_mask_bench.sv */
// Purpose: Self-checking bench for the state/stage interrupt enable block
// Assumes: One wait cycle per access, event pulses one cycle wide
// Notes: Register model kept in bench variables
module ssim_state_stage_irq_mask_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import ssim_pkg::*;
	logic clock, rstn, rd, wr, wse, rse, cend, irq, wt;
	logic [ADDR_W-1:0] adr;
	logic [DATA_W-1:0] wd, rdd, q, exp;
	logic [DS_W-1:0] ds;
	logic [BE_W-1:0] be;
	int en_model;
	int ds_q[$];
	logic [15:0] seed;
	int mismatches, total_checks, cycles;
	int bits[5] = '{B_CFG, B_SUSPEND_STATE_ENABLE, B_WR, B_RD, B_END};

	ssim_state_stage_irq_mask i_dut (.clock(clock), .rstn(rstn), .avs_address(adr),
		.avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be),
		.avs_readdata(rdd), .avs_waitrequest(wt), .device_state_field(ds),
		.wr_status_entry(wse), .rd_status_entry(rse), .ctrl_end(cend), .irq(irq));

	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		total_checks++;
		if (got !== want) begin
			mismatches++;
			$display("mismatch at %0t got %h exp %h", $time, got, want);
		end
	endtask : chk

	// Holds the request until waitrequest is sampled low at a rising edge
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		adr <= a;
		wd <= d;
		wr <= w;
		rd <= !w;
		do begin
			@(posedge clock);
		end while (wt !== 1'b0);
		q = rdd;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask : bus

	task automatic rdchk(input logic [3:0] a, input logic [31:0] want);
		bus(1'b0, a, 32'h0);
		chk(q, want);
	endtask : rdchk

	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			wrap_up();
		end
	end

	initial begin
		{rd, wr, wse, rse, cend} = 5'h0;
		adr = 4'h0;
		wd = 32'h0;
		be = 4'hf;
		en_model = 0;
		ds = DS_POWERED;
		rstn = 1'b0;
		repeat (5) @(posedge clock);
		rstn <= 1'b1;
		rdchk(OFF_ENABLE, 32'h0);
		rdchk(OFF_STATUS, 32'h0);
		chk({31'h0, irq}, 32'h0);
		$display("test 1 done");
		seed = 16'hf989;
		for (int i = 0; i < 6; i++) begin
			seed = lfsr(seed);
			be <= {3'h7, seed[15]};
			if (seed[15]) begin
				en_model = seed & ENB_IMPL;
			end
			bus(1'b1, OFF_ENABLE, {16'h0, seed});
			rdchk(OFF_ENABLE, en_model);
		end
		be <= 4'hf;
		$display("test 2 done");
		bus(1'b1, OFF_MASK, 32'h3);
		for (int k = 0; k < 5; k++) begin
			for (int e = 0; e < 2; e++) begin
				ds <= (k == 0) ? DS_ADDRESS : DS_CONFIGURED;
				repeat (2) @(posedge clock);
				bus(1'b1, OFF_ENABLE, 32'(e) << bits[k]);
				bus(1'b1, OFF_STATUS, 32'h3);
				@(posedge clock);
				case (k)
					0: ds <= DS_CONFIGURED;
					1: ds <= 3'h4;
					2: wse <= 1'b1;
					3: rse <= 1'b1;
					default: cend <= 1'b1;
				endcase
				@(posedge clock);
				{wse, rse, cend} <= 3'h0;
				exp = (e == 0) ? 32'h0 : 32'h1 << ((k < 2) ? ST_DEV : ST_CTRL);
				rdchk(OFF_STATUS, exp);
				@(negedge clock);
				chk({31'h0, irq}, {31'h0, exp != 0});
				rdchk(OFF_DSTATE, {29'h0, ds});
				rdchk(OFF_ENABLE, 32'(e) << bits[k]);
				bus(1'b1, OFF_MASK, 32'h0);
				@(negedge clock);
				chk({31'h0, irq}, 32'h0);
				bus(1'b1, OFF_MASK, 32'h3);
				bus(1'b1, OFF_STATUS, 32'h3);
				rdchk(OFF_STATUS, 32'h0);
			end
		end
		$display("test 3 done");
		for (int i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			ds <= seed[2:0];
			ds_q.push_back(seed[2:0]);
			repeat (2) @(posedge clock);
			rdchk(OFF_DSTATE, ds_q.pop_front());
		end
		$display("test 4 done");
		rstn <= 1'b0;
		repeat (2) @(posedge clock);
		rstn <= 1'b1;
		rdchk(OFF_ENABLE, 32'h0);
		rdchk(OFF_STATUS, 32'h0);
		chk({31'h0, irq}, 32'h0);
		$display("test 5 done");
		wrap_up();
	end
endmodule : ssim_state_stage_irq_mask_bench
